// ### hdl/xfer_engine_pkg.sv
// Shared constants for the interrupt triggered transfer engine.
// Assumes a 32-bit word wide internal memory bus with byte addressing.
package xfer_engine_pkg;
   // Transfer descriptor word field positions.
   localparam int unsigned SIZE_BIT = 0;
   localparam int unsigned SRC_MEM_BIT = 1;
   localparam int unsigned SRC_STEP_BIT = 2;
   localparam int unsigned DST_STEP_BIT = 3;
   localparam int unsigned SUM_BIT = 4;
   localparam int unsigned PAIR_LSB = 4;
   localparam int unsigned BURST_BIT = 5;
   localparam int unsigned IRQ_BIT = 6;
   localparam int unsigned CHAIN_BIT = 7;
   localparam int unsigned MULTI_BIT = 15;
   // Descriptor byte offsets.
   localparam logic [31:0] OFS_MODE = 32'h0000_0000;
   localparam logic [31:0] OFS_COUNT = 32'h0000_0002;
   localparam logic [31:0] OFS_ADDR0 = 32'h0000_0004;
   localparam logic [31:0] ADDR_WORD_BYTES = 32'h0000_0004;
   // Pointer step per item size.
   localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
   localparam logic [31:0] STEP_HALF = 32'h0000_0002;
   // Handler starts in the eighth cycle after completion.
   localparam int unsigned HANDLER_DELAY_CYC = 8;
   // Timing estimate terms.
   localparam int unsigned EST_BASE = 6;
   localparam int unsigned EST_ITEM = 26;
   localparam int unsigned EST_TAIL = 4;
   localparam int unsigned EST_CHAIN = 4;
   localparam int unsigned EST_MULTI_BASE = 21;
   localparam int unsigned EST_MULTI_ITEM = 11;
   localparam int unsigned EST_SUM_FIX = 7;
   localparam int unsigned EST_SUM_INC = 8;
   // Request priority level that starts the engine.
   localparam logic [2:0] START_LEVEL = 3'h7;
endpackage

// ### hdl/cycle_estimator.sv
// Computes the expected cycle total of one descriptor run.
// Assumes the mode word and count are stable while it is read.
`timescale 1ns/100ps
module cycle_estimator
   import xfer_engine_pkg::*;
(
   input wire logic [15:0] mode,
   input wire logic [15:0] count,
   output logic [31:0] estimate
);
   // Combines the documented terms for either operating style.
   always_comb begin
      int a;
      int b;
      int c;
      int d;
      int e;
      int m;
      int n;
      int k;
      a = mode[SRC_MEM_BIT] ? -1 : 0;
      b = mode[SRC_STEP_BIT] ? 0 : 1;
      c = mode[DST_STEP_BIT] ? 0 : 1;
      d = !mode[SUM_BIT] ? 0 : (mode[SRC_STEP_BIT] ? EST_SUM_INC : EST_SUM_FIX);
      e = mode[CHAIN_BIT] ? EST_CHAIN : 0;
      m = mode[BURST_BIT] ? int'(count) : 1;
      n = (count >= 16'h0002) ? 1 : 0;
      k = int'(mode[PAIR_LSB +: 3]);
      if (mode[MULTI_BIT]) begin
         estimate = 32'(EST_MULTI_BASE + (EST_MULTI_ITEM + b + c) * k);
      end else begin
         estimate = 32'(EST_BASE + (EST_ITEM + a + b + c + d) * m + (EST_TAIL + e) * n);
      end
   end
endmodule

// ### hdl/transfer_engine.sv
// Interrupt triggered descriptor transfer engine with its own bus master port.
// Assumes a single cycle handshake memory bus: req held until ack, rdata valid with ack.
`timescale 1ns/100ps
module transfer_engine
   import xfer_engine_pkg::*;
#(
   parameter int unsigned SRC_COUNT = 8
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [SRC_COUNT-1:0] periph_req,
   input wire logic [2:0] periph_level [SRC_COUNT],
   input wire logic [31:0] vector_base,
   input wire logic global_irq_mask,
   input wire logic [2:0] processor_priority_level,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [1:0] mem_size,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   output logic busy,
   output logic irq_block,
   output logic req_ack,
   output logic handler_start,
   output logic [31:0] handler_addr,
   output logic [31:0] cycle_estimate
);
   typedef enum logic [10:0] {
      S_IDLE = 11'h001, S_VEC = 11'h002, S_MODE = 11'h004, S_ADDR = 11'h008,
      S_SRD = 11'h010, S_ORD = 11'h020, S_WR = 11'h040, S_WBACK = 11'h080,
      S_CHAIN = 11'h100, S_FIN = 11'h200, S_HWAIT = 11'h400
   } state_t;

   state_t st_q, st_d;
   logic [$clog2(SRC_COUNT+1)-1:0] src_q, src_d;
   logic [31:0] vec_addr_q, vec_addr_d, base_q, base_d;
   logic [15:0] mode_q, mode_d, count_q, count_d;
   logic [31:0] words_q [15], words_d [15];
   logic [3:0] widx_q, widx_d, nwords_q, nwords_d, pair_q, pair_d, wbi_q, wbi_d;
   logic [31:0] data_q, data_d, est_q;
   logic [3:0] hcnt_q, hcnt_d;
   logic mem_req_q, mem_req_d, mem_we_q, mem_we_d;
   logic [31:0] mem_addr_q, mem_addr_d, mem_wdata_q, mem_wdata_d;
   logic [1:0] mem_size_q, mem_size_d;
   logic ack_q, ack_d, hstart_q, hstart_d;
   logic [31:0] haddr_q, haddr_d;
   logic [31:0] est_w;

   cycle_estimator u_est (
      .mode(mode_q),
      .count(count_q),
      .estimate(est_w)
   );

   wire multi = mode_q[MULTI_BIT];
   wire half = mode_q[SIZE_BIT];
   wire [31:0] step = half ? STEP_HALF : STEP_BYTE;
   wire sum_on = mode_q[SUM_BIT] && !multi;
   wire burst_on = mode_q[BURST_BIT] && !multi;
   wire chain_on = mode_q[CHAIN_BIT] && !multi;
   wire irq_on = mode_q[IRQ_BIT] && !multi;
   // Word slots: src, then sum_transfer_select if summing, dst, next pointer if chaining, handler pointer.
   wire [3:0] dst_i = sum_on ? 4'd2 : 4'd1;
   wire [3:0] nxt_i = dst_i + 4'd1;
   wire [3:0] hnd_i = chain_on ? nxt_i + 4'd1 : nxt_i;
   wire [3:0] ps_i = {pair_q[2:0], 1'b0};
   wire [3:0] pd_i = ps_i + 4'd1;
   wire [3:0] pairs = {1'b0, mode_q[PAIR_LSB +: 3]};

   // Picks the lowest requester raised at level seven.
   logic pick_v;
   logic [$clog2(SRC_COUNT+1)-1:0] pick_i;
   always_comb begin
      pick_v = 1'b0;
      pick_i = '0;
      for (int i = SRC_COUNT - 1; i >= 0; i--) begin
         if (periph_req[i] && periph_level[i] == START_LEVEL) begin
            pick_v = 1'b1;
            pick_i = ($clog2(SRC_COUNT+1))'(i);
         end
      end
   end

   // Bus address for a descriptor word at slot index.
   function automatic logic [31:0] slot_addr(input logic [31:0] b, input logic [3:0] i);
      slot_addr = b + OFS_ADDR0 + ADDR_WORD_BYTES * {28'h0, i};
   endfunction

   // Issues one bus cycle.
   function automatic logic [66:0] cyc(input logic we, input logic [31:0] a,
                                       input logic [1:0] sz, input logic [31:0] wd);
      cyc = {we, a, sz, wd};
   endfunction

   // Sequencer next state.
   always_comb begin
      logic [31:0] sum;
      logic [31:0] sd;
      sum = '0;
      sd = '0;
      st_d = st_q; src_d = src_q; vec_addr_d = vec_addr_q; base_d = base_q;
      mode_d = mode_q; count_d = count_q; words_d = words_q; widx_d = widx_q;
      nwords_d = nwords_q; pair_d = pair_q; wbi_d = wbi_q; data_d = data_q;
      hcnt_d = hcnt_q; mem_req_d = mem_req_q; mem_we_d = mem_we_q;
      mem_addr_d = mem_addr_q; mem_wdata_d = mem_wdata_q; mem_size_d = mem_size_q;
      ack_d = 1'b0; hstart_d = 1'b0; haddr_d = haddr_q;
      case (st_q)
         S_IDLE: begin
            if (pick_v) begin
               src_d = pick_i;
               ack_d = 1'b1;
               vec_addr_d = vector_base + {{(30-$clog2(SRC_COUNT+1)){1'b0}}, pick_i, 2'b00};
               {mem_we_d, mem_addr_d, mem_size_d, mem_wdata_d} =
                  cyc(1'b0, vec_addr_d, 2'd2, 32'h0);
               mem_req_d = 1'b1;
               st_d = S_VEC;
            end
         end
         S_VEC: if (mem_ack) begin
            base_d = mem_rdata;
            mem_addr_d = mem_rdata + OFS_MODE;
            st_d = S_MODE;
         end
         S_MODE: if (mem_ack) begin
            mode_d = mem_rdata[15:0];
            count_d = mem_rdata[31:16];
            if (mem_rdata[MULTI_BIT])
               nwords_d = {mem_rdata[PAIR_LSB +: 3], 1'b0};
            else
               nwords_d = 4'd2 + {3'd0, mem_rdata[SUM_BIT]} + {3'd0, mem_rdata[CHAIN_BIT]}
                          + {3'd0, mem_rdata[IRQ_BIT]};
            widx_d = '0;
            pair_d = '0;
            if (mem_rdata[31:16] == 16'h0000 && !mem_rdata[MULTI_BIT]) begin
               mem_req_d = 1'b0;
               st_d = S_IDLE;
            end else begin
               mem_addr_d = slot_addr(base_q, 4'd0);
               st_d = S_ADDR;
            end
         end
         S_ADDR: if (mem_ack) begin
            words_d[widx_q] = mem_rdata;
            widx_d = widx_q + 4'd1;
            if (widx_q + 4'd1 < nwords_q) mem_addr_d = slot_addr(base_q, widx_q + 4'd1);
            else begin
               sd = multi ? words_d[ps_i] : words_d[0];
               {mem_we_d, mem_addr_d, mem_size_d, mem_wdata_d} =
                  cyc(1'b0, sd, {1'b0, half}, 32'h0);
               mem_req_d = mode_q[SRC_MEM_BIT] || multi;
               data_d = sd;
               st_d = mem_req_d ? S_SRD : (sum_on ? S_ORD : S_WR);
               if (!mem_req_d && sum_on) begin
                  mem_req_d = 1'b1;
                  mem_addr_d = words_d[1];
               end
               if (!mem_req_d) begin
                  mem_req_d = 1'b1;
                  {mem_we_d, mem_addr_d, mem_size_d, mem_wdata_d} =
                     cyc(1'b1, words_d[dst_i], {1'b0, half}, sd);
               end
            end
         end
         S_SRD: if (mem_ack) begin
            data_d = mem_rdata;
            if (sum_on) begin
               mem_addr_d = words_q[1];
               st_d = S_ORD;
            end else begin
               {mem_we_d, mem_addr_d, mem_size_d, mem_wdata_d} =
                  cyc(1'b1, multi ? words_q[pd_i] : words_q[dst_i], {1'b0, half}, mem_rdata);
               st_d = S_WR;
            end
         end
         S_ORD: if (mem_ack) begin
            sum = data_q + mem_rdata;
            {mem_we_d, mem_addr_d, mem_size_d, mem_wdata_d} =
               cyc(1'b1, words_q[dst_i], {1'b0, half}, sum);
            st_d = S_WR;
         end
         S_WR: if (mem_ack) begin
            if (multi) begin
               pair_d = pair_q + 4'd1;
               if (pair_q + 4'd1 < pairs) begin
                  {mem_we_d, mem_addr_d, mem_size_d, mem_wdata_d} =
                     cyc(1'b0, words_q[ps_i + 4'd2], {1'b0, half}, 32'h0);
                  st_d = S_SRD;
               end else begin
                  mem_req_d = 1'b0;
                  st_d = S_IDLE;
               end
            end else begin
               count_d = count_q - 16'h0001;
               if (mode_q[SRC_STEP_BIT]) begin
                  words_d[0] = words_q[0] + step;
                  if (sum_on) words_d[1] = words_q[1] + step;
               end
               if (mode_q[DST_STEP_BIT]) words_d[dst_i] = words_q[dst_i] + step;
               wbi_d = '0;
               {mem_we_d, mem_addr_d, mem_size_d, mem_wdata_d} =
                  cyc(1'b1, base_q + OFS_MODE, 2'd2, {count_d, mode_q});
               st_d = S_WBACK;
            end
         end
         S_WBACK: if (mem_ack) begin
            if (wbi_q <= dst_i) begin
               {mem_we_d, mem_addr_d, mem_size_d, mem_wdata_d} =
                  cyc(1'b1, slot_addr(base_q, wbi_q), 2'd2, words_q[wbi_q]);
               wbi_d = wbi_q + 4'd1;
            end else if (count_q != 16'h0000 && burst_on) begin
               sd = words_q[0];
               data_d = sd;
               {mem_we_d, mem_addr_d, mem_size_d, mem_wdata_d} =
                  cyc(!mode_q[SRC_MEM_BIT] && !sum_on, mode_q[SRC_MEM_BIT] ? sd :
                      (sum_on ? words_q[1] : words_q[dst_i]), {1'b0, half}, sd);
               st_d = mode_q[SRC_MEM_BIT] ? S_SRD : (sum_on ? S_ORD : S_WR);
            end else if (count_q == 16'h0000 && chain_on) begin
               {mem_we_d, mem_addr_d, mem_size_d, mem_wdata_d} =
                  cyc(1'b1, vec_addr_q, 2'd2, words_q[nxt_i]);
               st_d = S_CHAIN;
            end else begin
               mem_req_d = 1'b0;
               st_d = S_FIN;
            end
         end
         S_CHAIN: if (mem_ack) begin
            mem_req_d = 1'b0;
            st_d = S_FIN;
         end
         S_FIN: begin
            if (count_q == 16'h0000 && irq_on) begin
               haddr_d = words_q[hnd_i];
               hcnt_d = 4'd2;
               st_d = S_HWAIT;
            end else
               st_d = S_IDLE;
         end
         S_HWAIT: begin
            hcnt_d = hcnt_q + 4'd1;
            if (hcnt_q == 4'(HANDLER_DELAY_CYC - 1)) begin
               hstart_d = 1'b1;
               st_d = S_IDLE;
            end
         end
         default: st_d = S_IDLE;
      endcase
   end

   // Registers the sequencer state and bus cycle.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= S_IDLE; src_q <= '0; vec_addr_q <= '0; base_q <= '0;
         mode_q <= '0; count_q <= '0; widx_q <= '0; nwords_q <= '0;
         pair_q <= '0; wbi_q <= '0; data_q <= '0; hcnt_q <= '0;
         mem_req_q <= 1'b0; mem_we_q <= 1'b0; mem_addr_q <= '0;
         mem_wdata_q <= '0; mem_size_q <= '0; ack_q <= 1'b0;
         hstart_q <= 1'b0; haddr_q <= '0; est_q <= '0;
         for (int i = 0; i < 15; i++) words_q[i] <= '0;
      end else begin
         st_q <= st_d; src_q <= src_d; vec_addr_q <= vec_addr_d; base_q <= base_d;
         mode_q <= mode_d; count_q <= count_d; widx_q <= widx_d; nwords_q <= nwords_d;
         pair_q <= pair_d; wbi_q <= wbi_d; data_q <= data_d; hcnt_q <= hcnt_d;
         mem_req_q <= mem_req_d; mem_we_q <= mem_we_d; mem_addr_q <= mem_addr_d;
         mem_wdata_q <= mem_wdata_d; mem_size_q <= mem_size_d; ack_q <= ack_d;
         hstart_q <= hstart_d; haddr_q <= haddr_d;
         est_q <= (st_q == S_ADDR && widx_q == 4'd0) ? est_w : est_q;
         words_q <= words_d;
      end
   end

   // Status outputs, all from flip-flops.
   // Blocking follows the freshly fetched mode word, so a stale burst mode is not applied.
   logic busy_q, blk_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_q <= 1'b0;
         blk_q <= 1'b0;
      end else begin
         busy_q <= st_d != S_IDLE;
         blk_q <= !(st_d inside {S_IDLE, S_VEC, S_MODE, S_HWAIT})
                  && (mode_d[BURST_BIT] || mode_d[MULTI_BIT]);
      end
   end

   assign mem_req = mem_req_q;
   assign mem_we = mem_we_q;
   assign mem_addr = mem_addr_q;
   assign mem_size = mem_size_q;
   assign mem_wdata = mem_wdata_q;
   assign busy = busy_q;
   assign irq_block = blk_q;
   assign req_ack = ack_q;
   assign handler_start = hstart_q;
   assign handler_addr = haddr_q;
   assign cycle_estimate = est_q;
endmodule

// ### sim/transfer_engine_checker.sv
// Concurrent checks on the ports of the transfer engine.
// Assumes one clock domain and the single handshake memory bus.
`timescale 1ns/100ps
module transfer_engine_checker
   import xfer_engine_pkg::*;
#(
   parameter int unsigned SRC_COUNT = 8
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [SRC_COUNT-1:0] periph_req,
   input wire logic [2:0] periph_level [SRC_COUNT],
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [1:0] mem_size,
   input wire logic mem_ack,
   input wire logic busy,
   input wire logic irq_block,
   input wire logic req_ack,
   input wire logic handler_start
);
   logic [SRC_COUNT-1:0] top_req;
   // Marks the sources whose level may start the engine.
   always_comb begin
      for (int i = 0; i < SRC_COUNT; i++) begin
         top_req[i] = periph_req[i] && (periph_level[i] == START_LEVEL);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_bus_held:
      assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("bus request changed before its answer");
   a_fetch_answered:
      assert property (req_ack |-> ##[0:40] mem_ack) else $error("vector fetch never answered");
   a_ack_reads:
      assert property (req_ack |-> mem_req && !mem_we) else $error("start without vector read");
   a_start_level:
      assert property (req_ack |-> $past(top_req) != '0) else $error("start without level request");
   a_ack_pulse:
      assert property (req_ack |=> !req_ack) else $error("request taken twice");
   a_bus_busy:
      assert property (mem_req |-> busy) else $error("bus cycle while idle");
   a_block_busy:
      assert property (irq_block |-> busy) else $error("blocking while idle");
   a_block_no_take:
      assert property (irq_block |-> !req_ack) else $error("request taken during burst");
   a_handler_idle:
      assert property (handler_start |-> !busy) else $error("handler start while busy");
   a_handler_pulse:
      assert property (handler_start |=> !handler_start) else $error("handler start too long");
   a_handler_delay:
      assert property (handler_start |-> $past(mem_req, 8) && !$past(mem_req, 7))
      else $error("handler start not in eighth cycle");
   a_size_legal:
      assert property (mem_req |-> mem_size != 2'h3) else $error("illegal bus size");
   // Main scenarios reached.
   c_handler: cover property (handler_start);
   c_burst: cover property (irq_block);
   c_half_write: cover property (mem_req && mem_we && mem_size == 2'h1);
endmodule

bind transfer_engine transfer_engine_checker #(.SRC_COUNT(SRC_COUNT)) chk_u (
   .clk(clk), .arst_n(arst_n), .periph_req(periph_req), .periph_level(periph_level),
   .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
   .mem_ack(mem_ack), .busy(busy), .irq_block(irq_block), .req_ack(req_ack),
   .handler_start(handler_start)
);

// ### sim/mem_model.sv
// Behavioural internal memory answering the engine's bus cycles.
// Assumes data travels right-aligned on the read and write data buses.
`timescale 1ns/100ps
module mem_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [2:0] wait_cyc,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [1:0] mem_size,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic mem_ack
);
   logic [7:0] bytes [1024];
   logic [2:0] wait_q;
   // Answers a held request after wait_cyc edges with a one-cycle ack.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_ack <= 1'b0;
         wait_q <= 3'h0;
         mem_rdata <= 32'h0;
      end else if (mem_ack) begin
         // Read data is not held once the cycle ends.
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end else if (mem_req && wait_q < wait_cyc) begin
         wait_q <= wait_q + 3'h1;
      end else if (mem_req) begin
         wait_q <= 3'h0;
         mem_ack <= 1'b1;
         for (int i = 0; i < 4; i++) begin
            if (i < (1 << mem_size)) begin
               if (mem_we)
                  bytes[10'(mem_addr + i)] = mem_wdata[8*i+:8];
               mem_rdata[8*i+:8] <= bytes[10'(mem_addr + i)];
            end else
               mem_rdata[8*i+:8] <= 8'h00;
         end
      end
   end
endmodule

// ### sim/test_interrupt_triggered_transfer_engine.sv
// Self-checking bench: descriptors in the memory model, requests on the sources.
// Assumes vector entries four bytes apart from a base of zero.
`timescale 1ns/100ps
module test_interrupt_triggered_transfer_engine;
   import xfer_engine_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] periph_req = 8'h00;
   logic [2:0] periph_level [8];
   logic [2:0] wait_cyc = 3'h0;
   logic mem_req, mem_we, mem_ack, busy, irq_block, req_ack, handler_start;
   logic [1:0] mem_size;
   logic [31:0] mem_addr, mem_wdata, mem_rdata, handler_addr, cycle_estimate, est_cap;
   int failures = 0;
   int check_count = 0;
   int handlers = 0;
   int acks = 0;
   int n0;
   bit blk_seen, est_taken;
   // Runs the 25 ns clock.
   always #12.5 clk = ~clk;
   transfer_engine #(.SRC_COUNT(8)) dut_u (.clk(clk), .arst_n(arst_n),
      .periph_req(periph_req), .periph_level(periph_level), .vector_base(32'h0),
      .global_irq_mask(1'b1), .processor_priority_level(3'h7), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy), .irq_block(irq_block),
      .req_ack(req_ack), .handler_start(handler_start), .handler_addr(handler_addr),
      .cycle_estimate(cycle_estimate));
   mem_model mem_u (.clk(clk), .arst_n(arst_n), .wait_cyc(wait_cyc), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   // Counts pulses, notes blocking and takes the estimate at the first write.
   always @(posedge clk) begin
      if (handler_start === 1'b1)
         handlers++;
      if (req_ack === 1'b1)
         acks++;
      if (irq_block === 1'b1)
         blk_seen = 1'b1;
      if (mem_req === 1'b1 && mem_we === 1'b1 && !est_taken) begin
         est_taken = 1'b1;
         est_cap = cycle_estimate;
      end
   end
   function automatic logic [31:0] rd(input int a);
      return {mem_u.bytes[a+3], mem_u.bytes[a+2], mem_u.bytes[a+1], mem_u.bytes[a]};
   endfunction
   task automatic wr(input int a, input logic [31:0] v);
      for (int i = 0; i < 4; i++)
         mem_u.bytes[a+i] = v[8*i+:8];
   endtask
   task automatic desc(input int b, input logic [15:0] md, cn, input int a0, a1, a2);
      wr(b, {cn, md});
      wr(b + 4, a0);
      wr(b + 8, a1);
      wr(b + 12, a2);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Raises one source until taken, then waits for the run and a handler window.
   task automatic fire(input int s);
      int n;
      n = 0;
      est_taken = 1'b0;
      @(posedge clk);
      periph_req[s] <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (req_ack !== 1'b1 && n < 40);
      periph_req[s] <= 1'b0;
      chk({31'h0, req_ack}, 32'h1, "request taken");
      n = 0;
      while (busy !== 1'b0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, busy}, 32'h0, "run finished");
      repeat (12) @(posedge clk);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      conclude();
   end
   initial begin
      foreach (periph_level[i])
         periph_level[i] = 3'h7;
      periph_level[2] = 3'h3;
      for (int i = 0; i < 1024; i++)
         mem_u.bytes[i] = 8'h00;
      wr(12'h000, 12'h100);
      wr(12'h004, 12'h200);
      wr(12'h300, 32'h0000_2211);
      desc(12'h100, 16'h004e, 16'h0002, 12'h300, 12'h340, 12'habc);
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      fire(0);
      chk(rd(12'h340), 32'h0000_0011, "single moves one item");
      chk(rd(12'h100), 32'h0001_004e, "count written back");
      chk(rd(12'h104), 32'h0000_0301, "source advanced");
      chk(handlers, 0, "handler before zero");
      fire(0);
      chk(rd(12'h340), 32'h0000_2211, "second item");
      chk(handlers, 1, "handler at zero");
      chk(handler_addr, 32'h0000_0abc, "handler address");
      $display("test single done");
      wait_cyc <= 3'h2;
      blk_seen = 1'b0;
      desc(12'h140, 16'h002f, 16'h0003, 12'h380, 12'h3c0, 0);
      wr(12'h380, 32'ha3a2_a1a0);
      wr(12'h384, 32'h0000_a5a4);
      wr(12'h000, 12'h140);
      fire(0);
      chk(rd(12'h3c0), 32'ha3a2_a1a0, "burst halves");
      chk(rd(12'h3c4), 32'h0000_a5a4, "burst end");
      chk({31'h0, blk_seen}, 32'h1, "blocked during burst");
      chk(est_cap, 32'd85, "burst estimate");
      chk(handlers, 1, "no handler when disabled");
      $display("test burst done");
      wait_cyc <= 3'h0;
      desc(12'h180, 16'h004e, 16'h0000, 12'h300, 12'h3e0, 12'habc);
      wr(12'h000, 12'h180);
      fire(0);
      chk(rd(12'h3e0), 32'h0, "zero count moves nothing");
      chk(handlers, 1, "zero count no handler");
      $display("test zero done");
      desc(12'h1c0, 16'h807e, 16'h0000, 0, 0, 0);
      for (int i = 0; i < 7; i++) begin
         wr(12'h1c4 + 8 * i, 12'h390 + i);
         wr(12'h1c8 + 8 * i, 12'h3d0 + 2 * i);
         mem_u.bytes[12'h390 + i] = 8'h50 + 8'(i);
      end
      wr(12'h000, 12'h1c0);
      fire(0);
      for (int i = 0; i < 7; i++)
         chk(mem_u.bytes[12'h3d0 + 2 * i], 8'h50 + 8'(i), "pair moved");
      chk(mem_u.bytes[12'h3de], 8'h00, "no extra pair");
      chk(handlers, 1, "no handler in multi");
      chk(est_cap, 32'd98, "multi estimate");
      $display("test multi done");
      desc(12'h200, 16'h008e, 16'h0001, 12'h300, 12'h3f0, 12'h240);
      desc(12'h240, 16'h000e, 16'h0001, 12'h301, 12'h3f1, 0);
      fire(1);
      chk(rd(12'h004), 32'h0000_0240, "vector rewritten");
      chk(mem_u.bytes[12'h3f0], 8'h11, "chain first item");
      chk(est_cap, 32'd31, "chain estimate");
      fire(1);
      chk(mem_u.bytes[12'h3f1], 8'h22, "next descriptor used");
      $display("test chain done");
      n0 = acks;
      periph_req[2] <= 1'b1;
      repeat (20) @(posedge clk);
      periph_req[2] <= 1'b0;
      chk(acks - n0, 0, "low level ignored");
      $display("test level done");
      conclude();
   end
endmodule
